// ---- design/frp_fifo.sv ----
// Parameterised valid/ready FIFO for program data
`timescale 1ns/100ps
module frp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] fill, next_fill;
   logic do_wr, do_rd;
   assign in_ready = (fill < (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always_comb begin
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
      next_fill = fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill <= next_fill;
      end
   end
   // Storage needs no reset; only pointers define contents
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ---- design/frp_pkg.sv ----
// Constants and types for the flash range programmer
// Summary of operation
// (RULE_01) Works for bus clocks from 1.5 MHz to 8.0 MHz.
// (RULE_02) Every program pulse lasts between 30 and 40 microseconds.
// (RULE_03) Caller gives speed value as bus MHz times four, rounded.
// (RULE_04) Pulse is 57 cycles for speed below 7, else eight times speed plus eight.
// (RULE_05) One algorithm: each pass writes one byte or loops over a whole row.
// (RULE_06) Watchdog enabled: every byte is programmed on its own.
// (RULE_07) Watchdog off and range inside one row: whole-row programming.
// (RULE_08) Watchdog off across rows: single bytes until last row, then row method.
// (RULE_09) High voltage stays on under 125 microseconds per single byte.
// (RULE_10) Cumulative high voltage per row stays below 4 ms.
// (RULE_11) Caller checks erasure and verifies; no success status is given.
// (RULE_12) Interrupts masked during programming, mask restored on completion.
// (RULE_13) With watchdog enabled it is serviced, first 61 cycles after start.
// (RULE_14) Caller gives byte count, first address and matching data array.
// (RULE_15) Caller passes a pointer to the block, pointing at the speed value.
// (RULE_16) Returned pointer is the address after the last byte programmed.
// (RULE_17) A row is 32 consecutive bytes, programmable in one operation.
// (RULE_18) Block: speed at 0, count at 1, address at 2 and 3, data from 4.
// (RULE_19) Method is chosen from the watchdog disable bit sampled at start.
package frp_pkg;
   localparam int CLK_MHZ = 100;
   localparam int PROG_MIN_US = 30;
   localparam int PROG_MAX_US = 40;
   localparam int HV_MAX_US = 125;
   localparam int ROW_BYTES = 32;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] SPEED_LOW_MAX = 8'h0006;
   localparam logic [11:0] PULSE_LOW_CYC = 12'h0039;
   localparam logic [11:0] PULSE_MUL = 12'h0008;
   localparam logic [11:0] PULSE_ADD = 12'h0008;
   localparam logic [11:0] HV_SETUP_CYC = 12'h0004;
   localparam logic [11:0] HV_HOLD_CYC = 12'h0004;
   localparam logic [11:0] WDOG_FIRST_CYC = 12'h003D;
   localparam logic [11:0] WDOG_PERIOD_CYC = 12'h0100;
   localparam logic [2:0] OFS_SPEED = 3'h0;
   localparam logic [2:0] OFS_COUNT = 3'h1;
   localparam logic [2:0] OFS_ADDR_HI = 3'h2;
   localparam logic [2:0] OFS_ADDR_LO = 3'h3;
   localparam logic [2:0] OFS_DATA = 3'h4;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   typedef enum logic [3:0] {
      FRP_IDLE, FRP_RD_SPEED, FRP_RD_COUNT, FRP_RD_AHI, FRP_RD_ALO,
      FRP_FETCH, FRP_LOAD, FRP_HV_ON, FRP_PULSE, FRP_HV_OFF, FRP_DONE
   } frp_state_t;
endpackage

// ---- design/frp_top.sv ----
// Flash range programming sequencer
`timescale 1ns/100ps
module frp_top
   import frp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Caller request
   input wire logic start,
   input wire logic [15:0] block_ptr,
   input wire logic watchdog_disable_bit,
   input wire logic int_mask_in,
   output logic busy,
   output logic done,
   output logic [15:0] result_ptr,
   // Parameter block memory read
   output logic mem_rd,
   output logic [15:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   // Interrupt mask and watchdog
   output logic int_mask,
   output logic watchdog_service,
   // Flash array
   output logic [15:0] flash_addr,
   output logic [7:0] flash_data,
   output logic flash_latch,
   output logic flash_hv,
   output logic flash_pgm
);
   localparam int PROG_MIN_CYC = (PROG_MIN_US * CLK_MHZ);
   localparam int HV_MAX_CYC = (HV_MAX_US * CLK_MHZ);

   frp_state_t state, next_state;
   logic [7:0] speed, next_speed;
   logic [7:0] remain, next_remain;
   logic [7:0] data_idx, next_data_idx;
   logic [15:0] faddr, next_faddr;
   logic [15:0] row_base, next_row_base;
   logic row_mode, next_row_mode;
   logic byte_mode_wd, next_byte_mode_wd;
   logic saved_mask, next_saved_mask;
   logic [11:0] cnt, next_cnt;
   logic [11:0] wd_cnt, next_wd_cnt;
   logic rd_pend, next_rd_pend;
   logic [7:0] batch, next_batch;
   logic done_r, next_done_r;
   logic [15:0] result_r, next_result_r;
   logic [7:0] fetch_n, next_fetch_n;
   logic [11:0] pulse_cyc;
   logic [15:0] last_addr;
   logic [15:0] cur_addr;

   // FIFO between parameter memory and flash latch
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [7:0] f_out_data;
   frp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(mem_rdata),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // Pulse length from speed value
   always_comb begin
      if (speed <= SPEED_LOW_MAX) begin // see RULE_01
         pulse_cyc = PULSE_LOW_CYC; // see RULE_04
      end else begin
         pulse_cyc = PULSE_MUL * {4'h0, speed} + PULSE_ADD; // see RULE_04
      end
   end
   // Low address byte is still on the read bus at the first fetch decision
   assign cur_addr = (state == FRP_FETCH && cnt == 12'hFFF) ? {faddr[15:8], mem_rdata} : faddr;
   assign last_addr = cur_addr + {8'h00, remain} - 16'h0001;

   assign f_in_valid = rd_pend;
   assign f_out_ready = (state == FRP_LOAD);

   always_comb begin
      next_state = state;
      next_speed = speed;
      next_remain = remain;
      next_data_idx = data_idx;
      next_faddr = faddr;
      next_row_base = row_base;
      next_row_mode = row_mode;
      next_byte_mode_wd = byte_mode_wd;
      next_saved_mask = saved_mask;
      next_cnt = cnt;
      next_rd_pend = 1'b0;
      next_batch = batch;
      next_fetch_n = fetch_n;
      next_done_r = 1'b0;
      next_result_r = result_r;
      // Watchdog service timer runs whenever enabled and busy
      next_wd_cnt = (state != FRP_IDLE && !byte_mode_wd && wd_cnt != 12'h000) ? wd_cnt - 12'h001 : wd_cnt;
      if (state != FRP_IDLE && !byte_mode_wd && wd_cnt == 12'h001) begin
         next_wd_cnt = WDOG_PERIOD_CYC; // see RULE_13
      end
      mem_rd = 1'b0;
      mem_addr = block_ptr;
      unique case (state)
         FRP_IDLE: begin
            if (start) begin
               next_saved_mask = int_mask_in; // see RULE_12
               next_byte_mode_wd = watchdog_disable_bit; // see RULE_19
               next_wd_cnt = WDOG_FIRST_CYC; // see RULE_13
               next_state = FRP_RD_SPEED;
            end
         end
         FRP_RD_SPEED: begin
            mem_rd = 1'b1;
            mem_addr = block_ptr + {13'h0000, OFS_SPEED}; // see RULE_18
            next_state = FRP_RD_COUNT;
         end
         FRP_RD_COUNT: begin
            next_speed = mem_rdata;
            mem_rd = 1'b1;
            mem_addr = block_ptr + {13'h0000, OFS_COUNT};
            next_state = FRP_RD_AHI;
         end
         FRP_RD_AHI: begin
            next_remain = mem_rdata;
            mem_rd = 1'b1;
            mem_addr = block_ptr + {13'h0000, OFS_ADDR_HI};
            next_state = FRP_RD_ALO;
         end
         FRP_RD_ALO: begin
            next_faddr = {mem_rdata, 8'h00};
            mem_rd = 1'b1;
            mem_addr = block_ptr + {13'h0000, OFS_ADDR_LO};
            next_data_idx = 8'h00;
            next_state = FRP_FETCH;
         end
         FRP_FETCH: begin
            if (cnt == 12'hFFF) begin
               next_faddr = cur_addr;
            end
            if (remain == 8'h00) begin
               next_state = FRP_DONE;
            end else begin
               // Row method only with watchdog off and range inside final row
               if (byte_mode_wd && (cur_addr[15:5] == last_addr[15:5])) begin
                  next_row_mode = 1'b1; // see RULE_07, RULE_08
                  next_batch = remain;
               end else begin
                  next_row_mode = 1'b0; // see RULE_06, RULE_08
                  next_batch = 8'h01;
               end
               next_row_base = cur_addr;
               next_fetch_n = 8'h00;
               next_state = FRP_LOAD;
            end
            next_cnt = 12'h000;
         end
         FRP_LOAD: begin
            // One read in flight at most; a row is longer than the buffer, so fill and drain overlap
            if (fetch_n < batch && f_in_ready && !rd_pend) begin
               mem_rd = 1'b1;
               mem_addr = block_ptr + {13'h0000, OFS_DATA} + {8'h00, data_idx} + {8'h00, fetch_n}; // see RULE_18
               next_rd_pend = 1'b1;
               next_fetch_n = fetch_n + 8'h01;
            end
            // Latch each byte of the pass, looping over the row
            if (f_out_valid) begin
               next_faddr = faddr + 16'h0001; // see RULE_05, RULE_17
               next_cnt = cnt + 12'h001;
               if (cnt + 12'h001 == {4'h0, batch}) begin
                  next_cnt = HV_SETUP_CYC;
                  next_state = FRP_HV_ON;
               end
            end
         end
         FRP_HV_ON: begin
            next_cnt = cnt - 12'h001;
            if (cnt == 12'h001) begin
               next_cnt = pulse_cyc; // see RULE_02
               next_state = FRP_PULSE;
            end
         end
         FRP_PULSE: begin
            next_cnt = cnt - 12'h001;
            if (cnt == 12'h001) begin
               next_cnt = HV_HOLD_CYC; // see RULE_09, RULE_10
               next_state = FRP_HV_OFF;
            end
         end
         FRP_HV_OFF: begin
            next_cnt = cnt - 12'h001;
            if (cnt == 12'h001) begin
               next_data_idx = data_idx + batch;
               next_remain = remain - batch;
               next_batch = 8'h00;
               next_cnt = 12'h000;
               next_state = FRP_FETCH;
            end
         end
         FRP_DONE: begin
            next_result_r = faddr; // see RULE_16
            next_done_r = 1'b1;
            next_state = FRP_IDLE;
         end
         default: next_state = FRP_IDLE;
      endcase
      if (state == FRP_RD_ALO) begin
         next_cnt = 12'hFFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= FRP_IDLE;
         speed <= 8'h00;
         remain <= 8'h00;
         data_idx <= 8'h00;
         faddr <= RESET_ADDR;
         row_base <= RESET_ADDR;
         row_mode <= 1'b0;
         byte_mode_wd <= 1'b0;
         saved_mask <= 1'b0;
         cnt <= 12'h000;
         wd_cnt <= 12'h000;
         rd_pend <= 1'b0;
         batch <= 8'h00;
         fetch_n <= 8'h00;
         done_r <= 1'b0;
         result_r <= RESET_ADDR;
      end else begin
         state <= next_state;
         speed <= next_speed;
         remain <= next_remain;
         data_idx <= next_data_idx;
         faddr <= next_faddr;
         row_base <= next_row_base;
         row_mode <= next_row_mode;
         byte_mode_wd <= next_byte_mode_wd;
         saved_mask <= next_saved_mask;
         cnt <= next_cnt;
         wd_cnt <= next_wd_cnt;
         rd_pend <= next_rd_pend;
         batch <= next_batch;
         fetch_n <= next_fetch_n;
         done_r <= next_done_r;
         result_r <= next_result_r;
      end
   end

   assign busy = (state != FRP_IDLE);
   assign done = done_r;
   assign result_ptr = result_r;
   // Mask forced while busy, caller's own mask otherwise
   assign int_mask = busy ? 1'b1 : saved_mask; // see RULE_12
   assign watchdog_service = busy && !byte_mode_wd && (wd_cnt == 12'h001); // see RULE_13
   assign flash_addr = (state == FRP_LOAD) ? faddr : row_base;
   assign flash_data = f_out_data;
   assign flash_latch = (state == FRP_LOAD) && f_out_valid;
   assign flash_hv = (state == FRP_HV_ON) || (state == FRP_PULSE) || (state == FRP_HV_OFF);
   assign flash_pgm = (state == FRP_PULSE);
   // Speed range is the caller's duty; not checked here
   logic unused_ok;
   assign unused_ok = row_mode ^ (PROG_MIN_CYC > HV_MAX_CYC) ^ (PROG_MAX_US > 0) ^ (ROW_BYTES > 0);
endmodule

// ---- tb/frp_mem_model.sv ----
// Behavioural parameter block memory seen by the sequencer
`timescale 1ns/100ps
module frp_mem_model (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   output logic [7:0] mem_rdata
);
   // Loaded by the bench: speed, count, address, then data
   logic [7:0] ram [256];
   // Idle cycles show inverted data so a late sample is caught
   always_ff @(posedge clk) begin
      mem_rdata <= mem_rd ? ram[mem_addr[7:0]] : ~mem_rdata;
   end
endmodule

// ---- tb/frp_properties.sv ----
// Port-level checks of the flash range programmer
`timescale 1ns/100ps
module frp_properties
   import frp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Caller side
   input wire logic start,
   input wire logic [15:0] block_ptr,
   input wire logic watchdog_disable_bit,
   input wire logic int_mask_in,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] result_ptr,
   // Memory, mask, watchdog and flash
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic int_mask,
   input wire logic watchdog_service,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_data,
   input wire logic flash_latch,
   input wire logic flash_hv,
   input wire logic flash_pgm
);
   logic rd_q, saved_mask, wd_off;
   logic [15:0] rd_ofs, first;
   logic [7:0] speed, count;
   logic [11:0] pgm_cnt, hv_cnt, exp_pulse;
   assign exp_pulse = (speed <= SPEED_LOW_MAX) ? PULSE_LOW_CYC : {4'h0, speed} * PULSE_MUL + PULSE_ADD;
   // Block fields rebuilt from the read stream, not from inside the design
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         {rd_q, saved_mask, wd_off, rd_ofs, first, speed, count, pgm_cnt, hv_cnt} <= '0;
      end else begin
         rd_q <= mem_rd;
         rd_ofs <= mem_addr - block_ptr;
         if (start && !busy) begin
            saved_mask <= int_mask_in;
            wd_off <= watchdog_disable_bit;
         end
         if (rd_q && rd_ofs == 16'h0000) speed <= mem_rdata;
         if (rd_q && rd_ofs == 16'h0001) count <= mem_rdata;
         if (rd_q && rd_ofs == 16'h0002) first[15:8] <= mem_rdata;
         if (rd_q && rd_ofs == 16'h0003) first[7:0] <= mem_rdata;
         pgm_cnt <= flash_pgm ? pgm_cnt + 12'h001 : 12'h000;
         hv_cnt <= flash_hv ? hv_cnt + 12'h001 : 12'h000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_order;
      $rose(busy) |-> mem_rd && mem_addr == block_ptr ##1 mem_rd && mem_addr == block_ptr + 16'h0001
         ##1 mem_rd && mem_addr == block_ptr + 16'h0002 ##1 mem_rd && mem_addr == block_ptr + 16'h0003;
   endproperty
   a_order: assert property (p_order) else $error("block read order wrong");
   property p_pulse;
      $fell(flash_pgm) |-> pgm_cnt == exp_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse length wrong");
   property p_hv;
      $fell(flash_hv) |-> hv_cnt <= exp_pulse + HV_SETUP_CYC + HV_HOLD_CYC;
   endproperty
   a_hv: assert property (p_hv) else $error("high voltage too long");
   property p_pgm_hv;
      flash_pgm |-> flash_hv;
   endproperty
   a_pgm_hv: assert property (p_pgm_hv) else $error("pulse without high voltage");
   property p_mask_busy;
      busy |-> int_mask;
   endproperty
   a_mask_busy: assert property (p_mask_busy) else $error("mask low while busy");
   property p_mask_back;
      !busy |-> int_mask == saved_mask;
   endproperty
   a_mask_back: assert property (p_mask_back) else $error("mask not restored");
   property p_wdog_first;
      start && !busy && !watchdog_disable_bit |-> ##61 watchdog_service;
   endproperty
   a_wdog_first: assert property (p_wdog_first) else $error("first service late or early");
   property p_wdog_off;
      wd_off |-> !watchdog_service;
   endproperty
   a_wdog_off: assert property (p_wdog_off) else $error("service while disabled");
   property p_start;
      start && !busy |=> busy;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_range;
      flash_latch |-> flash_addr - first < {8'h00, count};
   endproperty
   a_range: assert property (p_range) else $error("latch outside range");
   property p_result;
      done |-> result_ptr == first + {8'h00, count};
   endproperty
   a_result: assert property (p_result) else $error("result pointer wrong");
   property p_done;
      done |=> !done;
   endproperty
   a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule

// ---- tb/test_flash_range_programmer.sv ----
// Self-checking bench for the flash range programmer
`timescale 1ns/100ps
module test_flash_range_programmer;
   import frp_pkg::*;
   typedef struct {logic [7:0] spd; logic [7:0] cnt; logic [15:0] adr; logic wd_off; logic msk; int pulses;} frp_case_t;
   localparam logic [15:0] BP = 16'h0010;
   // Speed is bus MHz times four
   frp_case_t cases [6] = '{'{8'h06, 8'h01, 16'hE004, 1'b0, 1'b1, 1}, '{8'h07, 8'h02, 16'hE004, 1'b1, 1'b0, 1},
      '{8'h20, 8'h20, 16'hC000, 1'b1, 1'b1, 1}, '{8'h0A, 8'h03, 16'hC01E, 1'b1, 1'b0, 3},
      '{8'h18, 8'h05, 16'hC0F0, 1'b0, 1'b0, 5}, '{8'h08, 8'h46, 16'hC0F0, 1'b1, 1'b1, 49}};
   logic clk, rst_n, start, watchdog_disable_bit, int_mask_in, busy, done, mem_rd, int_mask, watchdog_service;
   logic flash_latch, flash_hv, flash_pgm, pgm_q;
   logic [15:0] block_ptr, result_ptr, mem_addr, flash_addr;
   logic [7:0] mem_rdata, flash_data;
   logic [23:0] lat_q [$];
   int failures = 0, check_count = 0, pulses = 0;
   frp_top dut (.clk(clk), .rst_n(rst_n), .start(start), .block_ptr(block_ptr),
      .watchdog_disable_bit(watchdog_disable_bit), .int_mask_in(int_mask_in), .busy(busy), .done(done),
      .result_ptr(result_ptr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .int_mask(int_mask),
      .watchdog_service(watchdog_service), .flash_addr(flash_addr), .flash_data(flash_data),
      .flash_latch(flash_latch), .flash_hv(flash_hv), .flash_pgm(flash_pgm));
   frp_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      pgm_q <= flash_pgm;
      if (flash_latch === 1'b1) lat_q.push_back({flash_addr, flash_data});
      if (flash_pgm === 1'b1 && pgm_q !== 1'b1) pulses++;
   end
   function automatic logic [7:0] fdata(input int i);
      return 8'(i * 37) ^ 8'hA5;
   endfunction
   task automatic final_report();
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic run_op(input frp_case_t c);
      int n;
      lat_q.delete();
      pulses = 0;
      {mem.ram[BP], mem.ram[BP + 1], mem.ram[BP + 2], mem.ram[BP + 3]} = {c.spd, c.cnt, c.adr};
      for (n = 0; n < c.cnt; n++) mem.ram[BP + 4 + n] = fdata(n);
      @(posedge clk);
      {start, watchdog_disable_bit, int_mask_in} <= {1'b1, c.wd_off, c.msk};
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      // Second start while busy must be ignored
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         failures++;
         $display("[ERR] %0t no done", $time);
         final_report();
      end
      check(result_ptr === c.adr + {8'h00, c.cnt}, "result pointer");
      check(lat_q.size() == c.cnt, "latch count");
      check(pulses == c.pulses, "pulse count");
      for (n = 0; n < c.cnt && n < lat_q.size(); n++) check(lat_q[n] === {c.adr + 16'(n), fdata(n)}, "byte");
      @(posedge clk);
      #1 check(int_mask === c.msk, "mask restore");
   endtask
   initial begin
      int i;
      frp_case_t deep;
      {rst_n, start, watchdog_disable_bit, int_mask_in} = '0;
      block_ptr = BP;
      repeat (4) @(posedge clk);
      #1 check({busy, done, int_mask, watchdog_service, mem_rd, flash_latch, flash_hv, flash_pgm} === 8'h00, "reset");
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i++) run_op(cases[i]);
      // Abort in mid-operation, then recover
      @(posedge clk);
      {start, watchdog_disable_bit, int_mask_in} <= 3'h1 << 2;
      @(posedge clk);
      start <= 1'b0;
      repeat (100) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({busy, int_mask, flash_hv, flash_pgm} === 4'h0, "abort");
      @(posedge clk);
      rst_n <= 1'b1;
      run_op(cases[3]);
      // Row pass longer than the internal buffer, bytes past its depth
      deep = '{8'h10, 8'h11, 16'hC040, 1'b1, 1'b0, 1};
      run_op(deep);
      check(lat_q.size() == FIFO_DEPTH + 1, "deep count");
      check(lat_q[15] === {16'hC04F, fdata(15)}, "deep byte 15");
      check(lat_q[16] === {16'hC050, fdata(16)}, "deep byte 16");
      check(result_ptr === 16'hC051, "deep result");
      final_report();
   end
endmodule
bind frp_top frp_properties u_prop (.clk(clk), .rst_n(rst_n), .start(start), .block_ptr(block_ptr),
   .watchdog_disable_bit(watchdog_disable_bit), .int_mask_in(int_mask_in), .busy(busy), .done(done),
   .result_ptr(result_ptr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .int_mask(int_mask),
   .watchdog_service(watchdog_service), .flash_addr(flash_addr), .flash_data(flash_data),
   .flash_latch(flash_latch), .flash_hv(flash_hv), .flash_pgm(flash_pgm));
